/* rtl/hardware_trap_unit.sv */
// hardware and software trap unit with an axi4-lite register slave
module hardware_trap_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [8:0] hw_trap_event,
  input wire logic sw_trap_request,
  input wire logic [6:0] sw_trap_number,
  input wire logic trap_return,
  output logic redirect_valid,
  output logic [23:0] redirect_address,
  output logic [6:0] redirect_number,
  output logic [1:0] redirect_level,
  output logic block_interrupts,
  output logic irq
);
  trap_path_if tp ();

  logic [8:0] trap_flag_register;
  logic [8:0] pending;
  logic [7:0] vector_table_segment;
  logic [1:0] vector_spacing_field;
  logic sw_pending;
  logic [6:0] sw_number;
  logic [1:0] current_level;
  logic [1:0] saved_level_0;
  logic [1:0] saved_level_1;
  logic [1:0] next_level;
  logic [1:0] next_saved_0;
  logic [1:0] next_saved_1;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] irq_event;
  logic [2:0] next_irq_status;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] write_mask;
  logic [31:0] clear_bits;
  logic [31:0] read_value;
  logic read_hit;

  // byte enables widened to a bit mask
  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // merge written bytes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [31:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction

  // shared path to arbiter and vector calculator
  assign tp.candidates = pending | hw_trap_event;
  assign tp.current_level = current_level;
  assign tp.sw_pending = sw_pending | sw_trap_request;
  assign tp.sw_number = sw_pending ? sw_number : sw_trap_number;
  assign tp.segment = vector_table_segment;
  assign tp.spacing = vector_spacing_field;

  trap_arbiter u_arbiter (
    .tp(tp.arbiter)
  );

  vector_address_calc u_calc (
    .tp(tp.calc)
  );

  // write takes place once both address and data are held
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_mask = byte_mask(w_strb);
  assign clear_bits = w_data & write_mask;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) aw_held <= 1'b0;
      // reopen only after the response has gone
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) w_held <= 1'b0;
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // write response; unmapped or read-only targets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= trap_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        trap_pkg::OFS_TRAP_FLAGS, trap_pkg::OFS_VECTOR_SEGMENT, trap_pkg::OFS_CPU_CONTROL_ONE,
        trap_pkg::OFS_IRQ_CLEAR, trap_pkg::OFS_IRQ_ENABLE: s_axi_bresp <= trap_pkg::RESP_OKAY;
        default: s_axi_bresp <= trap_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    read_value = '0;
    read_hit = 1'b1;
    unique case (s_axi_araddr)
      trap_pkg::OFS_TRAP_FLAGS: read_value = 32'(trap_flag_register);
      trap_pkg::OFS_VECTOR_SEGMENT: read_value = 32'(vector_table_segment);
      trap_pkg::OFS_CPU_CONTROL_ONE: read_value = 32'(vector_spacing_field);
      trap_pkg::OFS_SERVICE_STATUS: read_value = 32'({pending, sw_pending, saved_level_1, saved_level_0, current_level});
      trap_pkg::OFS_IRQ_STATUS: read_value = 32'(irq_status);
      trap_pkg::OFS_IRQ_ENABLE: read_value = 32'(irq_enable);
      trap_pkg::OFS_IRQ_CLEAR: read_value = '0;
      default: read_hit = 1'b0;
    endcase
  end

  // read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= trap_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_hit ? trap_pkg::RESP_OKAY : trap_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // trap flags: sticky, write one to clear, a new cause beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_flag_register <= '0;
    end else begin
      if (do_write && (aw_addr == trap_pkg::OFS_TRAP_FLAGS)) begin
        trap_flag_register <= (trap_flag_register & ~clear_bits[8:0]) | hw_trap_event;
      end else begin
        trap_flag_register <= trap_flag_register | hw_trap_event;
      end
    end
  end

  // causes not yet vectored; no mask exists for them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= '0;
    end else if (tp.take_valid && tp.take_hw) begin
      pending <= tp.candidates & ~tp.take_mask;
    end else begin
      pending <= tp.candidates;
    end
  end

  // software trap request, held while hardware traps go first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pending <= 1'b0;
      sw_number <= '0;
    end else begin
      sw_pending <= tp.sw_pending && !(tp.take_valid && !tp.take_hw);
      sw_number <= tp.sw_number;
    end
  end

  // vector table configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_table_segment <= trap_pkg::SEGMENT_RESET;
      vector_spacing_field <= trap_pkg::SPACING_RESET;
    end else if (do_write) begin
      if (aw_addr == trap_pkg::OFS_VECTOR_SEGMENT) begin
        vector_table_segment <= 8'(merge(32'(vector_table_segment), w_data, write_mask));
      end
      if (aw_addr == trap_pkg::OFS_CPU_CONTROL_ONE) begin
        vector_spacing_field <= 2'(merge(32'(vector_spacing_field), w_data, write_mask));
      end
    end
  end

  // service level stack: return pops, a hardware take pushes
  always_comb begin
    next_level = current_level;
    next_saved_0 = saved_level_0;
    next_saved_1 = saved_level_1;
    if (trap_return) begin
      next_level = saved_level_0;
      next_saved_0 = saved_level_1;
      next_saved_1 = trap_pkg::LEVEL_NONE;
    end
    if (tp.take_valid && tp.take_hw) begin
      next_saved_1 = next_saved_0;
      next_saved_0 = next_level;
      next_level = tp.take_level;
    end
  end

  // two saved levels cover none, class B, class A nesting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_level <= trap_pkg::LEVEL_NONE;
      saved_level_0 <= trap_pkg::LEVEL_NONE;
      saved_level_1 <= trap_pkg::LEVEL_NONE;
    end else begin
      current_level <= next_level;
      saved_level_0 <= next_saved_0;
      saved_level_1 <= next_saved_1;
    end
  end

  // hold off interrupts and event transfers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_interrupts <= 1'b0;
    end else begin
      block_interrupts <= next_level != trap_pkg::LEVEL_NONE;
    end
  end

  // redirect to the core, one cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      redirect_valid <= 1'b0;
      redirect_address <= '0;
      redirect_number <= '0;
      redirect_level <= trap_pkg::LEVEL_NONE;
    end else begin
      redirect_valid <= tp.take_valid;
      if (tp.take_valid) begin
        redirect_address <= tp.vector_address;
        redirect_number <= tp.take_number;
        // software traps keep the current level
        redirect_level <= tp.take_hw ? tp.take_level : current_level;
      end
    end
  end

  // interrupt events from each kind of take
  assign irq_event[trap_pkg::IRQ_CLASS_A] = tp.take_valid && (tp.take_level == trap_pkg::LEVEL_II);
  assign irq_event[trap_pkg::IRQ_CLASS_B] = tp.take_valid && (tp.take_level == trap_pkg::LEVEL_I);
  assign irq_event[trap_pkg::IRQ_SOFTWARE] = tp.take_valid && !tp.take_hw;

  // sticky status, event beats a clear in the same cycle
  always_comb begin
    next_irq_status = irq_status | irq_event;
    if (do_write && (aw_addr == trap_pkg::OFS_IRQ_CLEAR)) begin
      next_irq_status = (irq_status & ~clear_bits[2:0]) | irq_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (do_write && (aw_addr == trap_pkg::OFS_IRQ_ENABLE)) begin
        irq_enable <= 3'(merge(32'(irq_enable), w_data, write_mask));
      end
      // level output follows status one edge later
      irq <= (irq_status & irq_enable) != '0;
    end
  end
endmodule

/* rtl/trap_pkg.sv */
// shared constants for the hardware trap unit
package trap_pkg;
  // trap condition bit positions, also the trap flag register layout
  localparam int FLAG_COUNT = 9;
  localparam int IDX_SR0 = 0;
  localparam int IDX_STACK_OVERFLOW_FLAG = 1;
  localparam int IDX_STACK_UNDERFLOW_FLAG = 2;
  localparam int IDX_SOFTWARE_BREAK_FLAG = 3;
  localparam int IDX_SR1 = 4;
  localparam int IDX_UNDEFINED_OPCODE_FLAG = 5;
  localparam int IDX_MEMORY_ACCESS_ERROR_FLAG = 6;
  localparam int IDX_PROTECTED_INSTRUCTION_FAULT_FLAG = 7;
  localparam int IDX_ILLEGAL_WORD_OPERAND_FLAG = 8;
  localparam int CLASS_A_COUNT = 4;
  localparam logic [8:0] CLASS_A_MASK = 9'h00f;
  localparam logic [8:0] CLASS_B_MASK = 9'h1f0;

  // trap numbers
  localparam logic [6:0] NUM_SYSTEM_REQUEST_ZERO = 7'h02;
  localparam logic [6:0] NUM_STACK_OVERFLOW = 7'h04;
  localparam logic [6:0] NUM_STACK_UNDERFLOW = 7'h06;
  localparam logic [6:0] NUM_SOFTWARE_BREAK = 7'h08;
  localparam logic [6:0] NUM_CLASS_TWO_SHARED = 7'h0a;

  // service levels: none, class B (I), class A (II)
  localparam logic [1:0] LEVEL_NONE = 2'h0;
  localparam logic [1:0] LEVEL_I = 2'h1;
  localparam logic [1:0] LEVEL_II = 2'h2;

  // vector table geometry
  localparam int SEGMENT_WIDTH = 8;
  localparam int OFFSET_WIDTH = 16;
  localparam int ADDRESS_WIDTH = 24;
  localparam int BASE_SPACING_SHIFT = 2;
  localparam logic [7:0] SEGMENT_RESET = 8'h00;
  localparam logic [1:0] SPACING_RESET = 2'h0;
  localparam logic [15:0] SEGMENT_OFFSET_ZERO = 16'h0000;

  // register map, byte addresses
  localparam int AXI_ADDR_WIDTH = 8;
  localparam logic [7:0] OFS_TRAP_FLAGS = 8'h00;
  localparam logic [7:0] OFS_VECTOR_SEGMENT = 8'h04;
  localparam logic [7:0] OFS_CPU_CONTROL_ONE = 8'h08;
  localparam logic [7:0] OFS_SERVICE_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // interrupt events: class A taken, class B taken, software trap taken
  localparam int IRQ_COUNT = 3;
  localparam int IRQ_CLASS_A = 0;
  localparam int IRQ_CLASS_B = 1;
  localparam int IRQ_SOFTWARE = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/trap_path_if.sv */
// signals between the trap unit top, its arbiter and its vector calculator
interface trap_path_if;
  logic [8:0] candidates;
  logic [1:0] current_level;
  logic sw_pending;
  logic [6:0] sw_number;
  logic take_valid;
  logic take_hw;
  logic [6:0] take_number;
  logic [1:0] take_level;
  logic [8:0] take_mask;
  logic [7:0] segment;
  logic [1:0] spacing;
  logic [23:0] vector_address;

  modport top (output candidates, current_level, sw_pending, sw_number, segment, spacing,
               input take_valid, take_hw, take_number, take_level, take_mask, vector_address);
  modport arbiter (input candidates, current_level, sw_pending, sw_number,
                   output take_valid, take_hw, take_number, take_level, take_mask);
  modport calc (input take_number, segment, spacing, output vector_address);
endinterface

/* rtl/trap_arbiter.sv */
// picks the trap to take this cycle from pending causes and service level
module trap_arbiter (
  trap_path_if.arbiter tp
);
  logic [8:0] class_a;
  logic a_allowed;
  logic b_allowed;

  // lowest flag index wins among class A causes
  function automatic logic [6:0] class_a_number(input logic [8:0] c);
    logic [6:0] n;
    n = trap_pkg::NUM_SOFTWARE_BREAK;
    if (c[trap_pkg::IDX_STACK_UNDERFLOW_FLAG]) n = trap_pkg::NUM_STACK_UNDERFLOW;
    if (c[trap_pkg::IDX_STACK_OVERFLOW_FLAG]) n = trap_pkg::NUM_STACK_OVERFLOW;
    if (c[trap_pkg::IDX_SR0]) n = trap_pkg::NUM_SYSTEM_REQUEST_ZERO;
    return n;
  endfunction

  assign a_allowed = tp.current_level < trap_pkg::LEVEL_II;
  assign b_allowed = tp.current_level < trap_pkg::LEVEL_I;
  assign class_a = tp.candidates & trap_pkg::CLASS_A_MASK;

  // hardware first, then software at the current cpu priority
  always_comb begin
    tp.take_valid = 1'b0;
    tp.take_hw = 1'b0;
    tp.take_number = tp.sw_number;
    tp.take_level = trap_pkg::LEVEL_NONE;
    tp.take_mask = '0;
    if (a_allowed && (class_a != '0)) begin
      tp.take_valid = 1'b1;
      tp.take_hw = 1'b1;
      tp.take_number = class_a_number(class_a);
      tp.take_level = trap_pkg::LEVEL_II;
      tp.take_mask = class_a & ~(class_a - 9'h001);
    end else if (b_allowed && ((tp.candidates & trap_pkg::CLASS_B_MASK) != '0)) begin
      tp.take_valid = 1'b1;
      tp.take_hw = 1'b1;
      tp.take_number = trap_pkg::NUM_CLASS_TWO_SHARED;
      tp.take_level = trap_pkg::LEVEL_I;
      tp.take_mask = trap_pkg::CLASS_B_MASK;
    end else if (tp.sw_pending) begin
      tp.take_valid = 1'b1;
    end
  end
endmodule

/* rtl/vector_address_calc.sv */
// forms the vector address from segment, spacing and trap number
module vector_address_calc (
  trap_path_if.calc tp
);
  logic [23:0] base;
  logic [23:0] offset;

  assign base = {tp.segment, trap_pkg::SEGMENT_OFFSET_ZERO};
  assign offset = 24'(tp.take_number) << (trap_pkg::BASE_SPACING_SHIFT + int'(tp.spacing));
  assign tp.vector_address = base + offset;
endmodule

/* tb/trap_unit_sva.sv */
// concurrent checks on the ports of the trap unit
module trap_unit_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [8:0] hw_trap_event,
  input wire logic sw_trap_request,
  input wire logic [6:0] sw_trap_number,
  input wire logic redirect_valid,
  input wire logic [6:0] redirect_number,
  input wire logic [1:0] redirect_level,
  input wire logic block_interrupts,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // redirect taken while no hardware service was running
  sequence s_from_idle;
    redirect_valid && !$past(block_interrupts);
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_take_at_once: assert property (hw_trap_event != 9'h000 && !block_interrupts |=>
    redirect_valid && redirect_level != 2'h0) else $error("hardware cause not taken at once");
  chk_class_a_num: assert property (s_from_idle ##0 redirect_level == 2'h2 |->
    redirect_number inside {7'h02, 7'h04, 7'h06, 7'h08}) else $error("class A number wrong");
  chk_class_b_num: assert property (s_from_idle ##0 redirect_level == 2'h1 |->
    redirect_number == 7'h0a) else $error("class B number wrong");
  chk_block_raise: assert property (redirect_valid && redirect_level != 2'h0 |->
    block_interrupts) else $error("interrupts not held off in trap service");
  chk_sw_number: assert property (sw_trap_request && hw_trap_event == 9'h000 && !block_interrupts |=>
    redirect_valid && redirect_level == 2'h0 && redirect_number == $past(sw_trap_number))
    else $error("software trap redirect wrong");
  // bus timing as promised by the slave
  chk_write_resp: assert property (s_write_taken |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_ready_gap: assert property (s_write_taken |=> !s_axi_awready [*3]) else $error("write address ready too soon");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
endmodule

bind hardware_trap_unit trap_unit_sva trap_unit_sva_inst (.aclk, .aresetn, .hw_trap_event, .sw_trap_request,
  .sw_trap_number, .redirect_valid, .redirect_number, .redirect_level, .block_interrupts, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* tb/cpu_model.sv */
// behavioural pipeline side: raises trap causes and returns from service
module cpu_model (
  input wire logic aclk,
  output logic [8:0] hw_trap_event,
  output logic sw_trap_request,
  output logic [6:0] sw_trap_number,
  output logic trap_return
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet pipeline at start
  initial begin
    hw_trap_event = 9'h000;
    sw_trap_request = 1'b0;
    sw_trap_number = 7'h55;
    trap_return = 1'b0;
  end
  // one-cycle cause pulse
  task automatic hw(input logic [8:0] m);
    @(posedge aclk);
    hw_trap_event <= m;
    @(posedge aclk);
    hw_trap_event <= 9'h000;
  endtask
  // number is not held once the pulse is gone, so a stale value cannot pass
  task automatic sw(input logic [6:0] n);
    @(posedge aclk);
    sw_trap_request <= 1'b1;
    sw_trap_number <= n;
    @(posedge aclk);
    sw_trap_request <= 1'b0;
    sw_trap_number <= ~n;
  endtask
  // end of a service routine after a prompt or slow handler
  task automatic ret(input int slow);
    repeat (slow) @(posedge aclk);
    @(posedge aclk);
    trap_return <= 1'b1;
    @(posedge aclk);
    trap_return <= 1'b0;
  endtask
endmodule

/* tb/tb_hardware_trap_unit.sv */
// self-checking bench for the hardware trap unit
module tb_hardware_trap_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sw_trap_request, trap_return;
  logic redirect_valid, block_interrupts, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, redirect_level, r;
  logic [8:0] hw_trap_event;
  logic [6:0] sw_trap_number, redirect_number;
  logic [23:0] redirect_address;
  logic [7:0] seg;
  logic got;
  int n_mismatch, cmp_count;

  hardware_trap_unit hardware_trap_unit_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hw_trap_event, .sw_trap_request, .sw_trap_number, .trap_return,
    .redirect_valid, .redirect_address, .redirect_number, .redirect_level, .block_interrupts, .irq);
  cpu_model cpu_model_inst (.aclk, .hw_trap_event, .sw_trap_request, .sw_trap_number, .trap_return);

  // 250 MHz core clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // address and data offered together, bready held until the response
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    // protection bits are ignored by the slave, so they may move freely
    s_axi_awprot <= a[4:2];
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= a[4:2];
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // redirect is a one-cycle pulse, so look at every edge for a few cycles
  task automatic wait_redirect();
    got = 1'b0;
    repeat (6) begin
      @(posedge aclk);
      if (redirect_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  function automatic logic [23:0] vec(input logic [6:0] n, input int f);
    return {seg, 16'h0000} + (24'(n) << (2 + f));
  endfunction

  task automatic expect_take(input logic [6:0] n, input logic [1:0] lv, input int f);
    wait_redirect();
    check("redirect seen", 32'(got), 32'h0000_0001);
    check("trap number", 32'(redirect_number), 32'(n));
    check("service level", 32'(redirect_level), 32'(lv));
    check("vector address", 32'(redirect_address), 32'(vec(n, f)));
  endtask

  task automatic t_reset_values();
    axi_read(trap_pkg::OFS_TRAP_FLAGS);
    check("flags at reset", d, 32'h0000_0000);
    axi_read(trap_pkg::OFS_CPU_CONTROL_ONE);
    check("spacing at reset", d, 32'h0000_0000);
    axi_read(8'h1c);
    check("unmapped read resp", 32'(r), 32'(trap_pkg::RESP_SLVERR));
    axi_write(trap_pkg::OFS_SERVICE_STATUS, 32'h0000_ffff);
    check("read-only write resp", 32'(r), 32'(trap_pkg::RESP_SLVERR));
  endtask

  task automatic t_class_a();
    // a write whose low byte strobe is off must leave the segment alone
    axi_write(trap_pkg::OFS_VECTOR_SEGMENT, 32'h0000_00ff, 4'he);
    axi_read(trap_pkg::OFS_VECTOR_SEGMENT);
    check("segment strobe gated", d, 32'h0000_0000);
    seg = 8'h12;
    axi_write(trap_pkg::OFS_VECTOR_SEGMENT, 32'h0000_0012);
    axi_read(trap_pkg::OFS_VECTOR_SEGMENT);
    check("segment written", d, 32'h0000_0012);
    axi_write(trap_pkg::OFS_IRQ_ENABLE, 32'h0000_0007);
    for (int i = 0; i < 4; i++) begin
      cpu_model_inst.hw(9'h001 << i);
      expect_take(7'(2 * i + 2), trap_pkg::LEVEL_II, 0);
      check("block in service", 32'(block_interrupts), 32'h0000_0001);
      cpu_model_inst.ret(i);
    end
    // two class A causes at once: lower flag first, the other waits for the return
    cpu_model_inst.hw(9'h00c);
    expect_take(7'h06, trap_pkg::LEVEL_II, 0);
    cpu_model_inst.ret(0);
    expect_take(7'h08, trap_pkg::LEVEL_II, 0);
    cpu_model_inst.ret(0);
    axi_read(trap_pkg::OFS_TRAP_FLAGS);
    check("class A flags kept", d, 32'h0000_000f);
    check("irq raised", 32'(irq), 32'h0000_0001);
    axi_write(trap_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
    axi_write(trap_pkg::OFS_TRAP_FLAGS, 32'h0000_000f);
    axi_read(trap_pkg::OFS_TRAP_FLAGS);
    check("flags cleared", d, 32'h0000_0000);
    check("irq cleared", 32'(irq), 32'h0000_0000);
  endtask

  task automatic t_class_b();
    axi_write(trap_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    axi_write(trap_pkg::OFS_CPU_CONTROL_ONE, 32'h0000_0001);
    cpu_model_inst.hw(9'h1f0);
    expect_take(7'h0a, trap_pkg::LEVEL_I, 1);
    axi_read(trap_pkg::OFS_TRAP_FLAGS);
    check("class B flags", d, 32'h0000_01f0);
    check("irq masked", 32'(irq), 32'h0000_0000);
    cpu_model_inst.hw(9'h002);
    expect_take(7'h04, trap_pkg::LEVEL_II, 1);
    cpu_model_inst.hw(9'h020);
    wait_redirect();
    check("class B waits", 32'(got), 32'h0000_0000);
    axi_read(trap_pkg::OFS_SERVICE_STATUS);
    check("pending cause", 32'(d[15:7]), 32'h0000_0020);
    check("irq enabled", 32'(irq), 32'h0000_0001);
    cpu_model_inst.ret(0);
    wait_redirect();
    check("waits at level I", 32'(got), 32'h0000_0000);
    cpu_model_inst.ret(3);
    expect_take(7'h0a, trap_pkg::LEVEL_I, 1);
    cpu_model_inst.ret(0);
    axi_write(trap_pkg::OFS_TRAP_FLAGS, 32'h0000_01ff);
    axi_write(trap_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
  endtask

  task automatic t_sw_traps();
    logic [6:0] nums [4];
    nums = '{7'h7f, 7'h00, 7'h33, 7'h7f};
    for (int f = 0; f < 4; f++) begin
      axi_write(trap_pkg::OFS_CPU_CONTROL_ONE, 32'(f));
      cpu_model_inst.sw(nums[f]);
      expect_take(nums[f], trap_pkg::LEVEL_NONE, f);
    end
    // only software takes since the last clear
    axi_read(trap_pkg::OFS_IRQ_STATUS);
    check("software take status", d, 32'h0000_0004);
  endtask

  // drive every input at time zero, reset, then run the scenarios
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    seg = 8'h00;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    t_class_a();
    t_class_b();
    t_sw_traps();
    stop_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule
